// ### pkg/vfd_params.svh
// constants of the display scanner: offsets, fields, reset values, timing
// assumes byte-wide registers on a 12-bit address port
`ifndef VFD_PARAMS_SVH
`define VFD_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define VFD_CTL1_ADDR   12'h02a
`define VFD_CTL2_ADDR   12'h02b
`define VFD_CTL3_ADDR   12'h02c
`define VFD_STAT_ADDR   12'h02d
`define VFD_LATCH_BASE  12'h030
`define VFD_LATCH_LAST  12'h034
`define VFD_BUF_BASE    12'hf80
`define VFD_BUF_LAST    12'hfcf
`define VFD_BUF_BYTES   80
`define VFD_ROW_STRIDE  16

// ************************************************************
// reset values
// ************************************************************
`define VFD_CTL1_RST    8'h80
`define VFD_CTL2_RST    8'h20
`define VFD_CTL3_RST    8'h00

// ************************************************************
// field positions
// ************************************************************
`define VFD_BLK_BIT     7
`define VFD_COARSE_HI   6
`define VFD_COARSE_LO   5
`define VFD_WIDTH_HI    4
`define VFD_DIM_HI      7
`define VFD_DIM_LO      5
`define VFD_SLOTS_HI    4
`define VFD_SPLIT_HI    7
`define VFD_SPLIT_LO    3
`define VFD_PD_SLEW_BIT 2
`define VFD_GR_SLEW_BIT 1
`define VFD_FINE_BIT    0
`define VFD_WAIT_BIT    7

// ************************************************************
// timing: slot period is 2^exp cycles of the main oscillator
// ************************************************************
`define VFD_EXP_BASE    4'h9
`define VFD_SIXTEENTH   4'h4
`define VFD_CNT_W       12
`define VFD_PINS        37
`define VFD_MAX_WIDTH   5'h05

`endif

// ### pkg/vfd_pkg.sv
// types of the display scanner
// assumes vfd_params.svh for numeric constants
package vfd_pkg;
   typedef enum logic [1:0] {
      VFD_IDLE,
      VFD_ARM,
      VFD_PRIME,
      VFD_RUN
   } vfd_state_t;
   typedef logic [7:0] vfd_byte_t;
endpackage

// ### pkg/vfd_timing_if.sv
// signals between the scanner core and its slot timer
// assumes one clock domain, clk_sys
`timescale 1ns/1ps
`default_nettype none
interface vfd_timing_if;
   logic [1:0] coarse;
   logic       fine;
   logic [2:0] brightness_fraction;
   logic       slot_end;
   logic       grid_window;
   modport core  (output coarse, output fine, output brightness_fraction, input slot_end, input grid_window);
   modport timer (input coarse, input fine, input brightness_fraction, output slot_end, output grid_window);
endinterface
`default_nettype wire

// ### core/vfd_pin_sync.sv
// three-stage synchroniser for port pin levels
// assumes inputs asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module vfd_pin_sync #(
   parameter int W = 37
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_level
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // change counts once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         lvl_r <= '0;
      end else begin
         lvl_r <= (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
      end
   end

   assign pin_level = lvl_r;
endmodule
`default_nettype wire

// ### core/vfd_slot_timer.sv
// slot period counter and dimmer window
// assumes clk_sys is the main oscillator
`include "vfd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_slot_timer (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   vfd_timing_if.timer tif
);
   logic [`VFD_CNT_W-1:0] cnt_r;
   logic [3:0]            exp_w;
   logic [`VFD_CNT_W-1:0] last_w;
   logic [`VFD_CNT_W-1:0] frac_w;

   // on-time in sixteenths; reserved 000 taken as 001
   function automatic logic [4:0] on_sixteenths(input logic [2:0] d);
      logic [2:0] dd;
      dd = (d == 3'h0) ? 3'h1 : d;
      on_sixteenths = 5'h10 - {1'b0, dd, 1'b0};
   endfunction

   always_comb begin
      exp_w  = `VFD_EXP_BASE + {2'h0, tif.coarse} - {3'h0, tif.fine};
      last_w = `VFD_CNT_W'((13'h1 << exp_w) - 13'h1);
      frac_w = cnt_r >> (exp_w - `VFD_SIXTEENTH);
   end

   assign tif.slot_end    = (cnt_r >= last_w);
   assign tif.grid_window = (frac_w < {7'h0, on_sixteenths(tif.brightness_fraction)});

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else if (tif.slot_end) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + `VFD_CNT_W'(1);
      end
   end

   AST_SLOT_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tif.slot_end |=> (cnt_r == '0)) else $error("slot counter not restarted");
   AST_WINDOW_LEADS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (cnt_r == '0) |-> tif.grid_window) else $error("grid window not at slot start");
endmodule
`default_nettype wire

// ### core/vfd_scanner.sv
// automatic vacuum fluorescent display scanner, top level
// assumes byte register port on clk_sys, pins pulled down externally
//
// Overview of operation
// - dimmer code gates grids 14/16 down to 2/16
// - slot count code N gives N+1 slots
// - slot count alone drives no digit pin
// - slot period 2^(9..12)/fc, fine bit subtracts one
// - separate slow-rise selects for grid and extra ports
// - split code assigns grid pins from first pin
// - dimmer changes accepted while display runs
// - buffer fetched to outputs automatically each slot
// - buffer bit one drives its output active
// - five bytes per slot, row stride sixteen
// - buffer is display refresh only
// - clearing blanking starts scanning
// - several grid bits may share one slot
// - reset clears port latches; software keeps zero
// - output width N enables the first N extra port pins, none for N above 5
// - idle drops after slot, driving after next
// - blanking stops driving at slot end, idle set
// - standby forces blanking and clears outputs
//
// Chosen here: strobed register access.
`include "vfd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_scanner (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   input  wire logic [11:0]           reg_addr,
   input  wire vfd_pkg::vfd_byte_t    reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output vfd_pkg::vfd_byte_t         reg_rdata,
   input  wire logic                  standby_req,
   input  wire logic [36:0]           pin_in,
   output logic      [36:0]           pin_out,
   output logic      [36:0]           pin_oe,
   output logic                       grid_port_slow_rise,
   output logic                       extra_port_slow_rise,
   output logic                       display_idle
);
   import vfd_pkg::*;

   // ************************************************************
   // storage
   // ************************************************************
   vfd_byte_t   ctl1_r;
   vfd_byte_t   ctl2_r;
   vfd_byte_t   ctl3_r;
   vfd_byte_t   rdata_r;
   vfd_byte_t   buf_r [0:`VFD_BUF_BYTES-1];
   logic [36:0] latch_r;
   logic [36:0] pin_out_r;
   logic [36:0] pin_level;
   logic [36:0] disp_w;
   logic [36:0] row_w;
   logic [15:0] grid_w;
   logic [3:0]  slot_r;
   logic        wait_r;
   vfd_state_t  state_r;
   logic        drive_w;
   logic        blank_w;
   logic        slot_end;
   logic        grid_window;

   vfd_timing_if tif ();

   vfd_slot_timer u_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tif     (tif.timer)
   );

   vfd_pin_sync #(.W(`VFD_PINS)) u_sync (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .pin_in    (pin_in),
      .pin_level (pin_level)
   );

   // ************************************************************
   // decode helpers
   // ************************************************************
   function automatic logic is_buf(input logic [11:0] a);
      is_buf = (a >= `VFD_BUF_BASE) && (a <= `VFD_BUF_LAST);
   endfunction

   function automatic logic is_latch(input logic [11:0] a);
      is_latch = (a >= `VFD_LATCH_BASE) && (a <= `VFD_LATCH_LAST);
   endfunction

   function automatic logic [6:0] buf_idx(input logic [11:0] a);
      buf_idx = 7'(a - `VFD_BUF_BASE);
   endfunction

   function automatic logic [2:0] latch_idx(input logic [11:0] a);
      latch_idx = 3'(a - `VFD_LATCH_BASE);
   endfunction

   // last active slot; reserved codes fall back to one slot
   function automatic logic [3:0] slot_last(input logic [4:0] c);
      slot_last = c[4] ? 4'h0 : c[3:0];
   endfunction

   // ************************************************************
   // configuration fields
   // ************************************************************
   assign blank_w              = ctl1_r[`VFD_BLK_BIT];
   assign tif.coarse           = ctl1_r[`VFD_COARSE_HI:`VFD_COARSE_LO];
   assign tif.fine             = ctl3_r[`VFD_FINE_BIT];
   assign tif.brightness_fraction              = ctl2_r[`VFD_DIM_HI:`VFD_DIM_LO];
   assign slot_end             = tif.slot_end;
   assign grid_window          = tif.grid_window;
   assign grid_port_slow_rise  = ctl3_r[`VFD_GR_SLEW_BIT];
   assign extra_port_slow_rise = ctl3_r[`VFD_PD_SLEW_BIT];
   assign display_idle         = wait_r;

   // ************************************************************
   // register writes
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctl1_r <= `VFD_CTL1_RST;
      end else if (standby_req) begin
         ctl1_r[`VFD_BLK_BIT] <= 1'b1;
      end else if (reg_wr && reg_addr == `VFD_CTL1_ADDR) begin
         ctl1_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctl2_r <= `VFD_CTL2_RST;
         ctl3_r <= `VFD_CTL3_RST;
      end else if (reg_wr && reg_addr == `VFD_CTL2_ADDR) begin
         ctl2_r <= reg_wdata;
      end else if (reg_wr && reg_addr == `VFD_CTL3_ADDR) begin
         ctl3_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         latch_r <= '0;
      end else if (reg_wr && is_latch(reg_addr)) begin
         for (int i = 0; i < 8; i++) begin
            if ({latch_idx(reg_addr), 3'(i)} < 6'h25) begin
               latch_r[{latch_idx(reg_addr), 3'(i)}] <= reg_wdata[i];
            end
         end
      end
   end

   // buffer is refresh storage only, contents undefined until written
   always_ff @(posedge clk_sys) begin
      if (reg_wr && is_buf(reg_addr)) begin
         buf_r[buf_idx(reg_addr)] <= reg_wdata;
      end
   end

   // ************************************************************
   // register reads, data one cycle after the strobe
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `VFD_CTL1_ADDR) begin
            rdata_r <= ctl1_r;
         end else if (reg_addr == `VFD_CTL2_ADDR) begin
            rdata_r <= ctl2_r;
         end else if (reg_addr == `VFD_CTL3_ADDR) begin
            rdata_r <= ctl3_r;
         end else if (reg_addr == `VFD_STAT_ADDR) begin
            rdata_r <= {wait_r, 7'h00};
         end else if (is_latch(reg_addr)) begin
            rdata_r <= 8'({3'h0, pin_level} >> {latch_idx(reg_addr), 3'h0});
         end else if (is_buf(reg_addr)) begin
            rdata_r <= buf_r[buf_idx(reg_addr)];
         end else begin
            rdata_r <= 8'h00;
         end
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;

   // ************************************************************
   // scan sequencing
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_r <= VFD_IDLE;
         wait_r  <= 1'b1;
      end else if (standby_req) begin
         state_r <= VFD_IDLE;
         wait_r  <= 1'b1;
      end else begin
         case (state_r)
            VFD_IDLE: begin
               if (!blank_w) begin
                  state_r <= VFD_ARM;
               end
            end
            VFD_ARM: begin
               if (blank_w) begin
                  state_r <= VFD_IDLE;
               end else if (slot_end) begin
                  state_r <= VFD_PRIME;
                  wait_r  <= 1'b0;
               end
            end
            VFD_PRIME: begin
               if (slot_end) begin
                  state_r <= blank_w ? VFD_IDLE : VFD_RUN;
                  wait_r  <= blank_w;
               end
            end
            VFD_RUN: begin
               if (slot_end && blank_w) begin
                  state_r <= VFD_IDLE;
                  wait_r  <= 1'b1;
               end
            end
            default: begin
               state_r <= VFD_IDLE;
               wait_r  <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         slot_r <= 4'h0;
      end else if (state_r != VFD_RUN) begin
         slot_r <= 4'h0;
      end else if (slot_end) begin
         if (slot_r >= slot_last(ctl2_r[`VFD_SLOTS_HI:0])) begin
            slot_r <= 4'h0;
         end else begin
            slot_r <= slot_r + 4'h1;
         end
      end
   end

   // ************************************************************
   // output data path
   // ************************************************************
   assign drive_w = (state_r == VFD_RUN) && !standby_req;

   always_comb begin
      row_w = {buf_r[{3'h4, slot_r}][4:0],
               buf_r[{3'h3, slot_r}],
               buf_r[{3'h2, slot_r}],
               buf_r[{3'h1, slot_r}],
               buf_r[{3'h0, slot_r}]};
      for (int i = 0; i < 5; i++) begin
         if (5'(i) >= ctl1_r[`VFD_WIDTH_HI:0] || ctl1_r[`VFD_WIDTH_HI:0] > `VFD_MAX_WIDTH) begin
            row_w[32 + i] = 1'b0;
         end
      end
      for (int i = 0; i < 16; i++) begin
         grid_w[i] = !ctl3_r[`VFD_SPLIT_HI] &&
                     (4'(i) <= ctl3_r[`VFD_SPLIT_HI-1:`VFD_SPLIT_LO]);
      end
      disp_w = row_w;
      if (!grid_window) begin
         disp_w[15:0] = row_w[15:0] & ~grid_w;
      end
      if (!drive_w) begin
         disp_w = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pin_out_r <= '0;
      end else begin
         pin_out_r <= disp_w | latch_r;
      end
   end

   // source open drain: pin driven only while high
   assign pin_out = pin_out_r;
   assign pin_oe  = pin_out_r;

   // ************************************************************
   // checks
   // ************************************************************
   AST_IDLE_DROP: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_ARM && slot_end && !blank_w && !standby_req) |=> !wait_r)
      else $error("idle flag not dropped at slot end");
   AST_DRIVE_START: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_PRIME && slot_end && !blank_w && !standby_req) |=> state_r == VFD_RUN)
      else $error("driving did not start after second slot end");
   AST_BLANK_STOP: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_RUN && slot_end && blank_w) |=> (wait_r && state_r == VFD_IDLE))
      else $error("blanking did not stop at slot end");
   AST_STANDBY_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
      standby_req |=> (blank_w && wait_r && ((pin_out_r & ~$past(latch_r)) == '0)))
      else $error("standby did not blank and clear outputs");
   AST_SLOT_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_RUN && !standby_req && !blank_w && slot_end
       && slot_r == slot_last(ctl2_r[`VFD_SLOTS_HI:0])) |=> slot_r == 4'h0)
      else $error("slot index did not wrap");
   AST_SLOT_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_RUN && !standby_req && !blank_w && !slot_end) |=> $stable(slot_r))
      else $error("slot index moved inside a slot");
   AST_GRID_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!grid_window) |=> ((pin_out_r[15:0] & $past(grid_w) & ~$past(latch_r[15:0])) == '0))
      else $error("grid driven outside dimmer window");
   AST_READ_STATUS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && reg_addr == `VFD_STAT_ADDR) |=> reg_rdata[`VFD_WAIT_BIT] == $past(wait_r))
      else $error("status read does not show idle flag");
   AST_QUIET_UNLESS_RUN: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r != VFD_RUN) |=> (pin_out_r == $past(latch_r)))
      else $error("pins driven while not scanning");
   AST_ARM_WAITS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_ARM) |-> wait_r)
      else $error("idle flag low before first slot end");
   AST_RUN_ACTIVE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (state_r == VFD_RUN) |-> !wait_r)
      else $error("idle flag high while scanning");
   AST_WIDTH_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (ctl1_r[`VFD_WIDTH_HI:0] == 5'h00) |=> (pin_out_r[36:32] == $past(latch_r[36:32])))
      else $error("extra port pin driven with zero output width");
   AST_SEG_WHOLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
      drive_w |=> (pin_out_r[36:16] == ($past(row_w[36:16]) | $past(latch_r[36:16]))))
      else $error("segment pins do not follow buffer row");
   AST_WINDOW_PASS: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (drive_w && grid_window)
      |=> (pin_out_r[15:0] == ($past(row_w[15:0]) | $past(latch_r[15:0]))))
      else $error("grid pins masked inside dimmer window");
endmodule
`default_nettype wire

// ### sim/vfd_tube_model.sv
// far-side model: tube grids and segments on pulled-down high-voltage pins
// assumes pin_oe high wherever the scanner sources a pin
`timescale 1ns/1ps
`default_nettype none
module vfd_tube_model (
   input  wire logic [36:0] pin_out,
   input  wire logic [36:0] pin_oe,
   input  wire logic [36:0] ext_en,
   input  wire logic [36:0] ext_val,
   output logic      [36:0] pin_in
);
   // ************************************************************
   // pin level seen back by the scanner
   // ************************************************************
   always_comb begin
      for (int i = 0; i < 37; i++) begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else
            pin_in[i] = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### sim/vfd_scanner_tb.sv
// self-checking bench of the display scanner
// assumes vfd_params.svh on the include path and the tube model beside it
`include "vfd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vfd_scanner_tb;
   import vfd_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   logic        clk_sys;
   logic        rst_b;
   logic [11:0] reg_addr;
   vfd_byte_t   reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   vfd_byte_t   reg_rdata;
   logic        standby_req;
   logic [36:0] pin_in;
   logic [36:0] pin_out;
   logic [36:0] pin_oe;
   logic        grid_port_slow_rise;
   logic        extra_port_slow_rise;
   logic        display_idle;
   logic [36:0] ext_en;
   logic [36:0] ext_val;
   logic [7:0]  bufd [0:79];
   logic [7:0]  d;
   logic [7:0]  q;
   int          error_cnt;
   int          comparisons;
   int          cyc;
   int          t0;
   int          seed;
   int          j;

   vfd_scanner vfd_scanner_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby_req(standby_req),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .grid_port_slow_rise(grid_port_slow_rise), .extra_port_slow_rise(extra_port_slow_rise),
      .display_idle(display_idle)
   );
   vfd_tube_model vfd_tube_model_inst (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
   );

   // ************************************************************
   // clock, cycle count, watchdog
   // ************************************************************
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
   end
   initial begin
      #320000;
      error_cnt++;
      results();
   end

   // ************************************************************
   // compare, bus and timing tasks
   // ************************************************************
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pins(input logic [36:0] got, input logic [36:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic tick(input int c);
      while (cyc < c) begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ************************************************************
   // expectations
   // ************************************************************
   function automatic logic [36:0] exp_pins(input int k, input bit grid_on, input int w);
      logic [36:0] v;
      v = {bufd[64+k][4:0], bufd[48+k], bufd[32+k], bufd[16+k], bufd[k]};
      for (int i = 32; i < 37; i++) begin
         if (i - 32 >= w)
            v[i] = 1'b0;
      end
      for (int i = 0; i <= 3; i++) begin
         if (!grid_on)
            v[i] = 1'b0;
      end
      return v;
   endfunction
   task automatic start(input logic [7:0] c1, input int p);
      int n;
      wr(`VFD_CTL1_ADDR, c1);
      #1;
      n = 0;
      while (display_idle !== 1'b0 && n < 3 * p) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk_bit(n <= p + 2, 1'b1);
      t0 = cyc + p + 1;
   endtask
   task automatic chk_slot(input int s, input int p, input int w, input int win);
      tick(t0 + s * p + 2);
      chk_pins(pin_out, exp_pins(s % 3, 1, w));
      chk_pins(pin_oe, exp_pins(s % 3, 1, w));
      tick(t0 + s * p + win + 3);
      chk_pins(pin_out, exp_pins(s % 3, 0, w));
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      standby_req = 1'b0;
      ext_en = 37'h0;
      ext_val = 37'h0;
      cyc = 0;
      seed = 64910;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`VFD_CTL1_ADDR, d); chk_byte(d, `VFD_CTL1_RST);
      rd(`VFD_CTL2_ADDR, d); chk_byte(d, `VFD_CTL2_RST);
      rd(`VFD_CTL3_ADDR, d); chk_byte(d, `VFD_CTL3_RST);
      rd(`VFD_STAT_ADDR, d); chk_byte(d, 8'h80);
      rd(`VFD_LATCH_BASE, d); chk_byte(d, 8'h00);
      chk_pins(pin_out, 37'h0);
      wr(12'h100, 8'hff);
      rd(12'h100, d); chk_byte(d, 8'h00);
      // port latch drive and pin read back
      d = $random(seed);
      wr(`VFD_LATCH_BASE, d);
      tick(cyc + 6);
      chk_byte(pin_out[7:0], d);
      rd(`VFD_LATCH_BASE, q); chk_byte(q, d);
      wr(`VFD_LATCH_BASE, 8'h00);
      ext_en  <= {5'h1f, 32'h0};
      ext_val <= {$random(seed), $random(seed)};
      tick(cyc + 8);
      rd(`VFD_LATCH_LAST, d); chk_byte(d, {3'h0, ext_val[36:32]});
      ext_en <= 37'h0;
      // configuration while blanked
      wr(`VFD_CTL3_ADDR, 8'h1d);
      wr(`VFD_CTL2_ADDR, 8'h22);
      for (int i = 0; i < 80; i++) begin
         bufd[i] = $random(seed);
         bufd[i][3:0] = (i < 3) ? 4'h1 << i : bufd[i][3:0];
         bufd[i][7] = (i >= 48 && i < 64) ? 1'b0 : bufd[i][7];
         wr(`VFD_BUF_BASE + 12'(i), bufd[i]);
      end
      tick(cyc + 2);
      chk_bit(extra_port_slow_rise, 1'b1);
      chk_bit(grid_port_slow_rise, 1'b0);
      chk_pins(pin_out, 37'h0);
      // first run: 256-cycle slots, all extra pins
      start(8'h05, 256);
      for (j = 0; j < 6; j++) begin
         chk_slot(j, 256, 5, 224);
      end
      for (int dm = 0; dm < 8; dm++) begin
         tick(t0 + j * 256 - 20);
         wr(`VFD_CTL2_ADDR, {3'(dm), 5'h02});
         chk_slot(j, 256, 5, (dm == 0) ? 224 : (16 - 2 * dm) * 16);
         j++;
      end
      // blanking in mid slot
      tick(t0 + j * 256 + 10);
      wr(`VFD_CTL1_ADDR, 8'h85);
      tick(t0 + j * 256 + 20);
      chk_pins(pin_out, exp_pins(j % 3, 1, 5));
      tick(t0 + j * 256 + 259);
      chk_pins(pin_out, 37'h0);
      chk_bit(display_idle, 1'b1);
      rd(`VFD_STAT_ADDR, d); chk_bit(d[7], 1'b1);
      // second run: 1024-cycle slots, no extra pins
      wr(`VFD_CTL1_ADDR, 8'ha0);
      wr(`VFD_CTL3_ADDR, 8'h1a);
      wr(`VFD_CTL2_ADDR, 8'h22);
      bufd[0][3:0] = 4'h3;
      wr(`VFD_BUF_BASE, bufd[0]);
      tick(cyc + 2);
      chk_bit(grid_port_slow_rise, 1'b1);
      start(8'h20, 1024);
      for (j = 0; j < 3; j++) begin
         chk_slot(j, 1024, 0, 896);
      end
      // standby during scanning
      tick(t0 + j * 1024 + 5);
      @(posedge clk_sys);
      standby_req <= 1'b1;
      tick(cyc + 3);
      chk_pins(pin_out, 37'h0);
      chk_bit(display_idle, 1'b1);
      rd(`VFD_CTL1_ADDR, d); chk_byte(d, 8'ha0);
      wr(`VFD_CTL1_ADDR, 8'h20);
      rd(`VFD_CTL1_ADDR, d); chk_byte(d, 8'ha0);
      rd(`VFD_CTL2_ADDR, d); chk_byte(d, 8'h22);
      @(posedge clk_sys);
      standby_req <= 1'b0;
      tick(cyc + 4);
      results();
   end
endmodule
`default_nettype wire
